/* File: prio_irq_defs.svh */
`ifndef PRIO_IRQ_DEFS_SVH
`define PRIO_IRQ_DEFS_SVH
// Overview of operation
// - equal tier requests granted in fixed poll order
// - power management alone forms the topmost tier
// - external wake-up from deep sleep leaves pending request
// - external flags frozen while core is in deep sleep
// - temperature and serial bus requests latched until entry
// - rtc request follows alarm and interval flags
// - some vectors never clear their request flags
// - external flag cleared on vectoring only in edge mode
// - grant pushes pc, loads vector; return pops pc
// - vectors eight bytes apart in documented order
// - no vectoring right after return or enable access
// - at least 3.25 instruction cycles request to handler
// - worst case latency at most 16.25 instruction cycles
// - only program counter saved by hardware
// - temperature request has no visible flag
// - timer two request is overflow or external flag
// - higher tier preempts, same tier never preempts
// - global enable bit gates every request source

// source indices in polling order, 0 polled first
`define NUM_SRC 13
`define SRC_PSM 0
`define SRC_RTC 1
`define SRC_ADE 2
`define SRC_WDT 3
`define SRC_TEMP 4
`define SRC_EXT0 5
`define SRC_TMR0 6
`define SRC_EXT1 7
`define SRC_TMR1 8
`define SRC_SER 9
`define SRC_UART 10
`define SRC_TMR2 11
`define SRC_UART2 12

// vector table: base plus slot times step
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define SLOT_EXT0 4'h0
`define SLOT_TMR0 4'h1
`define SLOT_EXT1 4'h2
`define SLOT_TMR1 4'h3
`define SLOT_UART 4'h4
`define SLOT_TMR2 4'h5
`define SLOT_TEMP 4'h6
`define SLOT_SER 4'h7
`define SLOT_PSM 4'h8
`define SLOT_ADE 4'h9
`define SLOT_RTC 4'hA
`define SLOT_WDT 4'hB
`define SLOT_UART2 4'hC

// sources whose flag is cleared by hardware when vectored (ext bits gated by edge mode)
`define AUTO_CLEAR_MASK 13'h01E0
// sources that must never see a hardware clear
`define NO_AUTO_MASK 13'h1C05

// timing
`define CLK_NS 25
`define LAT_MIN_NS 800
`define LAT_MAX_NS 4000
`define LAT_MIN_CYC ((`LAT_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define LAT_MAX_CYC (`LAT_MAX_NS / `CLK_NS)
`define WAIT_W 8
`endif

/* File: prio_irq_pkg.sv */
package prio_irq_pkg;
  typedef logic [3:0] src_idx_t;
  typedef logic [3:0] vec_slot_t;
  typedef logic [15:0] vec_addr_t;
  typedef enum logic [1:0] {TIER_LOW, TIER_HIGH, TIER_POWER} tier_t;
endpackage

/* File: arb_if.sv */
`timescale 1ns/1ps
interface arb_if;
  import prio_irq_pkg::*;
  logic [12:0] req;
  logic [12:0] high;
  logic [2:0] active;
  logic win_valid;
  src_idx_t win_idx;
  tier_t win_tier;
  modport arb (input req, input high, input active, output win_valid, output win_idx, output win_tier);
  modport ctl (output req, output high, output active, input win_valid, input win_idx, input win_tier);
endinterface

/* File: prio_arbiter.sv */
`timescale 1ns/1ps
module prio_arbiter
  import prio_irq_pkg::*;
(
  arb_if.arb bus
);

  // tier of each source: power management fixed on top, others from priority bits
  function automatic tier_t tier_of(input int idx, input logic [12:0] high);
    tier_t t;
    t = TIER_LOW;
    if (idx == 0) begin
      t = TIER_POWER;
    end else if (high[idx]) begin
      t = TIER_HIGH;
    end
    return t;
  endfunction

  // highest tier above everything in service wins; ties go to lowest poll index
  always_comb begin
    int top;
    top = bus.active[2] ? 2 : bus.active[1] ? 1 : bus.active[0] ? 0 : -1;
    bus.win_valid = 1'b0;
    bus.win_idx = '0;
    bus.win_tier = TIER_LOW;
    for (int t = 2; t >= 0; t--) begin
      for (int i = 0; i < 13; i++) begin
        // same tier as running handler never preempts
        if (!bus.win_valid && t > top && bus.req[i] && int'(tier_of(i, bus.high)) == t) begin
          bus.win_valid = 1'b1;
          bus.win_idx = src_idx_t'(i);
          bus.win_tier = tier_of(i, bus.high);
        end
      end
    end
  end
endmodule

/* File: priority_interrupt_vectoring.sv */
`timescale 1ns/1ps
`include "prio_irq_defs.svh"
module priority_interrupt_vectoring
  import prio_irq_pkg::*;
#(
  parameter int LAT_MIN_CYC = `LAT_MIN_CYC,
  parameter int LAT_MAX_CYC = `LAT_MAX_CYC
)(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic global_irq_enable_in,
  input wire logic [12:0] source_enable_in,
  input wire logic [12:0] priority_high_in,
  input wire logic ext_pin0_b_in,
  input wire logic ext_pin1_b_in,
  input wire logic ext_pin0_edge_select_in,
  input wire logic ext_pin1_edge_select_in,
  input wire logic ext_wake0_in,
  input wire logic ext_wake1_in,
  input wire logic deep_sleep_state_in,
  input wire logic power_mgmt_flag_in,
  input wire logic rtc_alarm_flag_in,
  input wire logic rtc_interval_flag_in,
  input wire logic energy_irq_flag_in,
  input wire logic watchdog_timeout_flag_in,
  input wire logic temperature_event_in,
  input wire logic serial_bus_event_in,
  input wire logic timer_zero_overflow_in,
  input wire logic timer_one_overflow_in,
  input wire logic timer_two_overflow_in,
  input wire logic timer_two_external_flag_in,
  input wire logic uart_rx_flag_in,
  input wire logic uart_tx_flag_in,
  input wire logic second_uart_rx_flag_in,
  input wire logic second_uart_tx_flag_in,
  input wire logic instr_boundary_in,
  input wire logic return_from_interrupt_in,
  input wire logic irq_sfr_access_in,
  output logic vector_load_out,
  output logic push_pc_out,
  output logic pop_pc_out,
  output logic [15:0] vector_addr_out,
  output logic [12:0] flag_clear_out,
  output logic ext_pin0_flag_out,
  output logic ext_pin1_flag_out,
  output logic [2:0] in_service_out
);

  localparam logic [`WAIT_W-1:0] WAIT_MIN = `WAIT_W'(LAT_MIN_CYC - 1);
  localparam logic [`WAIT_W-1:0] WAIT_MAX = `WAIT_W'(LAT_MAX_CYC);

  arb_if arb ();

  logic [12:0] raw_req;
  logic [12:0] elig_req;
  logic [1:0] ext_flag_r;
  logic [1:0] ext_wake_pend_r;
  logic [1:0] ext_fall;
  logic [1:0] pin_b;
  logic [1:0] edge_sel;
  logic [1:0] wake_evt;
  logic temp_pend_r;
  logic ser_pend_r;
  logic [`WAIT_W-1:0] wait_cnt_r;
  logic block_r;
  logic grant;
  logic [2:0] in_service_r;
  logic vector_load_r;
  logic push_pc_r;
  logic pop_pc_r;
  vec_addr_t vector_addr_r;
  logic [12:0] flag_clear_r;

  assign pin_b = {ext_pin1_b_in, ext_pin0_b_in};
  assign edge_sel = {ext_pin1_edge_select_in, ext_pin0_edge_select_in};
  assign wake_evt = {ext_wake1_in, ext_wake0_in};

  ////////////////////////////////////////////////////////////////////////////
  // external pins: synchroniser, flag and wake-up pending per pin

  generate
    for (genvar e = 0; e < 2; e++) begin : g_ext
      localparam int SRC = (e == 0) ? `SRC_EXT0 : `SRC_EXT1;
      logic sync1_r;
      logic sync2_r;
      logic prev_r;
      logic hit;

      // pin is asynchronous; the first stage feeds only the second
      always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          sync1_r <= 1'b1;
          sync2_r <= 1'b1;
          prev_r <= 1'b1;
        end else begin
          sync1_r <= pin_b[e];
          sync2_r <= sync1_r;
          prev_r <= sync2_r;
        end
      end

      assign ext_fall[e] = prev_r & ~sync2_r;
      assign hit = grant && arb.win_idx == src_idx_t'(SRC);

      // flag is frozen in deep sleep; a new falling edge beats the vectoring clear
      always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          ext_flag_r[e] <= 1'b0;
        end else if (deep_sleep_state_in) begin
          ext_flag_r[e] <= ext_flag_r[e];
        end else if (edge_sel[e]) begin
          if (ext_fall[e]) begin
            ext_flag_r[e] <= 1'b1;
          end else if (hit) begin
            ext_flag_r[e] <= 1'b0;
          end
        end else begin
          // level mode: handler re-entered until pin returns high
          ext_flag_r[e] <= ~sync2_r;
        end
      end

      // wake-up from deep sleep leaves a pending request apart from the flag
      always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          ext_wake_pend_r[e] <= 1'b0;
        end else if (wake_evt[e]) begin
          ext_wake_pend_r[e] <= 1'b1;
        end else if (hit) begin
          ext_wake_pend_r[e] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // latched sources without a software flag

  // temperature: internal latch only, nothing software can read or clear
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      temp_pend_r <= 1'b0;
    end else if (temperature_event_in) begin
      temp_pend_r <= 1'b1;
    end else if (grant && arb.win_idx == src_idx_t'(`SRC_TEMP)) begin
      temp_pend_r <= 1'b0;
    end
  end

  // serial bus: clearing status bits upstream does not reach this latch
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ser_pend_r <= 1'b0;
    end else if (serial_bus_event_in) begin
      ser_pend_r <= 1'b1;
    end else if (grant && arb.win_idx == src_idx_t'(`SRC_SER)) begin
      ser_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request vector in poll order

  always_comb begin
    raw_req = '0;
    raw_req[`SRC_PSM] = power_mgmt_flag_in;
    raw_req[`SRC_RTC] = rtc_alarm_flag_in | rtc_interval_flag_in;
    raw_req[`SRC_ADE] = energy_irq_flag_in;
    raw_req[`SRC_WDT] = watchdog_timeout_flag_in;
    raw_req[`SRC_TEMP] = temp_pend_r;
    raw_req[`SRC_EXT0] = ext_flag_r[0] | ext_wake_pend_r[0];
    raw_req[`SRC_TMR0] = timer_zero_overflow_in;
    raw_req[`SRC_EXT1] = ext_flag_r[1] | ext_wake_pend_r[1];
    raw_req[`SRC_TMR1] = timer_one_overflow_in;
    raw_req[`SRC_SER] = ser_pend_r;
    raw_req[`SRC_UART] = uart_rx_flag_in | uart_tx_flag_in;
    raw_req[`SRC_TMR2] = timer_two_overflow_in | timer_two_external_flag_in;
    raw_req[`SRC_UART2] = second_uart_rx_flag_in | second_uart_tx_flag_in;
  end

  // disabled requests stay pending in their latches, they just do not compete
  assign elig_req = raw_req & source_enable_in & {13{global_irq_enable_in}};

  assign arb.req = elig_req;
  assign arb.high = priority_high_in;
  assign arb.active = in_service_r;

  prio_arbiter u_arb (
    .bus(arb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // grant timing

  // counts cycles a winner has waited; saturates so it never wraps past the bound
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_cnt_r <= '0;
    end else if (!arb.win_valid || grant) begin
      wait_cnt_r <= '0;
    end else if (wait_cnt_r != WAIT_MAX) begin
      wait_cnt_r <= wait_cnt_r + `WAIT_W'(1);
    end
  end

  // one more instruction must finish after a return or an enable/priority access
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      block_r <= 1'b0;
    end else if (return_from_interrupt_in || irq_sfr_access_in) begin
      block_r <= 1'b1;
    end else if (instr_boundary_in) begin
      block_r <= 1'b0;
    end
  end

  // vectoring only at an instruction boundary and after the least latency
  assign grant = arb.win_valid && instr_boundary_in && !block_r && !return_from_interrupt_in &&
                 !irq_sfr_access_in && (wait_cnt_r >= WAIT_MIN);

  ////////////////////////////////////////////////////////////////////////////
  // in-service tiers

  // return closes the highest open tier; grant is never taken in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_service_r <= 3'h0;
    end else if (grant) begin
      in_service_r[arb.win_tier] <= 1'b1;
    end else if (return_from_interrupt_in) begin
      if (in_service_r[2]) begin
        in_service_r[2] <= 1'b0;
      end else if (in_service_r[1]) begin
        in_service_r[1] <= 1'b0;
      end else begin
        in_service_r[0] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector address and core strobes

  function automatic vec_slot_t slot_of(input src_idx_t idx);
    vec_slot_t s;
    unique case (idx)
      4'h0: s = `SLOT_PSM;
      4'h1: s = `SLOT_RTC;
      4'h2: s = `SLOT_ADE;
      4'h3: s = `SLOT_WDT;
      4'h4: s = `SLOT_TEMP;
      4'h5: s = `SLOT_EXT0;
      4'h6: s = `SLOT_TMR0;
      4'h7: s = `SLOT_EXT1;
      4'h8: s = `SLOT_TMR1;
      4'h9: s = `SLOT_SER;
      4'hA: s = `SLOT_UART;
      4'hB: s = `SLOT_TMR2;
      4'hC: s = `SLOT_UART2;
      default: s = `SLOT_EXT0;
    endcase
    return s;
  endfunction

  // only the pc is pushed; accumulator and status stay the handler's job
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vector_load_r <= 1'b0;
      push_pc_r <= 1'b0;
      pop_pc_r <= 1'b0;
    end else begin
      vector_load_r <= grant;
      push_pc_r <= grant;
      pop_pc_r <= return_from_interrupt_in;
    end
  end

  // address held until the next grant so the core may sample late
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vector_addr_r <= `VEC_BASE;
    end else if (grant) begin
      vector_addr_r <= 16'(`VEC_BASE + (16'(slot_of(arb.win_idx)) * `VEC_STEP));
    end
  end

  // hardware clear strobes; psm, rtc, energy, uart and timer two are left alone
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flag_clear_r <= 13'h0000;
    end else begin
      flag_clear_r <= '0;
      if (grant) begin
        flag_clear_r <= (13'h0001 << arb.win_idx) & `AUTO_CLEAR_MASK &
                        ~{5'h00, ~edge_sel[1], 1'b0, ~edge_sel[0], 5'h00};
      end
    end
  end

  assign vector_load_out = vector_load_r;
  assign push_pc_out = push_pc_r;
  assign pop_pc_out = pop_pc_r;
  assign vector_addr_out = vector_addr_r;
  assign flag_clear_out = flag_clear_r;
  assign ext_pin0_flag_out = ext_flag_r[0];
  assign ext_pin1_flag_out = ext_flag_r[1];
  assign in_service_out = in_service_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_POLL_ORDER: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (arb.win_valid && arb.win_tier == TIER_LOW && in_service_r == 3'h0)
      |-> ((elig_req & ~priority_high_in & ((13'h0001 << arb.win_idx) - 13'h0001)) == 13'h0000))
    else $error("lower index low tier request skipped");

  AST_POWER_TOP: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (elig_req[`SRC_PSM] && !in_service_r[2]) |-> (arb.win_valid && arb.win_idx == 4'h0))
    else $error("power management request not top winner");

  AST_SLEEP_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    deep_sleep_state_in |=> (ext_pin0_flag_out == $past(ext_pin0_flag_out) &&
                             ext_pin1_flag_out == $past(ext_pin1_flag_out)))
    else $error("external flag changed in deep sleep");

  AST_TEMP_LATCH: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (temp_pend_r && !(grant && arb.win_idx == 4'h4)) |=> temp_pend_r)
    else $error("temperature request lost without handler entry");

  AST_RTC_FOLLOW: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (!rtc_alarm_flag_in && !rtc_interval_flag_in) |=> !(vector_load_out && vector_addr_out == 16'h0053))
    else $error("rtc vectored without a flag");

  AST_NO_AUTO_CLEAR: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (flag_clear_out & `NO_AUTO_MASK) == 13'h0000)
    else $error("hardware clear on a software cleared source");

  AST_LEVEL_NO_CLEAR: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (grant && arb.win_idx == 4'h5 && !ext_pin0_edge_select_in) |=> !flag_clear_out[`SRC_EXT0])
    else $error("level mode external flag cleared on vectoring");

  AST_PSM_VECTOR: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (grant && arb.win_idx == 4'h0) |=> (vector_load_out && vector_addr_out == 16'h0043))
    else $error("wrong power management vector");

  AST_BLOCK_AFTER_RETURN_FROM_INTERRUPT: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (return_from_interrupt_in || irq_sfr_access_in) |=> !vector_load_out ##1 !vector_load_out)
    else $error("vectored directly after return or enable access");

  AST_LAT_MIN: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    vector_load_out |-> ($past(arb.win_valid, 1) && $past(arb.win_valid, LAT_MIN_CYC)))
    else $error("vectored before least latency");

  AST_T2_OR: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (!timer_two_overflow_in && !timer_two_external_flag_in) |=> !(vector_load_out && vector_addr_out == 16'h002B))
    else $error("timer two vectored without either flag");

  AST_SAME_TIER: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (grant && in_service_r[1]) |-> arb.win_tier == TIER_POWER)
    else $error("handler preempted by its own tier");

  AST_GLOBAL_GATE: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    !global_irq_enable_in |=> !vector_load_out)
    else $error("vectored with global enable off");
endmodule

/* File: core_model.sv */
`timescale 1ns/1ps
module core_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic slow_in,
  input wire logic push_pc_in,
  input wire logic pop_pc_in,
  output logic instr_boundary_out,
  output logic [3:0] depth_out
);
  logic [1:0] phase_r;

  //////////////////////////////////////////////////////////////////////
  // slow mode stands for multi-cycle instructions: one boundary in four
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign instr_boundary_out = !slow_in || (phase_r == 2'h3);

  //////////////////////////////////////////////////////////////////////
  // return stack holds the program counter only, one entry per vector
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      depth_out <= 4'h0;
    end else begin
      depth_out <= depth_out + {3'h0, push_pc_in} - {3'h0, pop_pc_in};
    end
  end
endmodule

/* File: priority_interrupt_vectoring_bench.sv */
`timescale 1ns/1ps
module priority_interrupt_vectoring_bench;
  import prio_irq_pkg::*;
  localparam int LMIN = 2;
  localparam logic [3:0] SLOT [13] = '{4'h8, 4'hA, 4'h9, 4'hB, 4'h6, 4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h4, 4'h5, 4'hC};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ge = 1'b0;
  logic slp = 1'b0;
  logic slow = 1'b0;
  logic rfi = 1'b0;
  logic sfr = 1'b0;
  logic tev = 1'b0;
  logic sev = 1'b0;
  logic wk1 = 1'b0;
  logic es0 = 1'b0;
  logic es1 = 1'b0;
  logic [12:0] en = '0;
  logic [12:0] hi = '0;
  logic [12:0] src = '0;
  logic [12:0] alt = '0;
  logic [12:0] p = '0;
  logic bnd, vl, push, pop, x0, x1;
  logic [15:0] va;
  logic [12:0] fc;
  logic [2:0] is;
  logic [3:0] depth;
  int fail_count = 0;
  int checks = 0;
  int n;
  int w;

  always #12.5 clk = ~clk;

  //////////////////////////////////////////////////////////////////////
  // level sources come from src; alt picks which of a pair raises it
  priority_interrupt_vectoring #(.LAT_MIN_CYC(LMIN), .LAT_MAX_CYC(8)) dut (
    .core_clk_in(clk), .rst_b_in(rst_b), .global_irq_enable_in(ge), .source_enable_in(en),
    .priority_high_in(hi), .ext_pin0_b_in(~src[5]), .ext_pin1_b_in(~src[7]),
    .ext_pin0_edge_select_in(es0), .ext_pin1_edge_select_in(es1), .ext_wake0_in(1'b0),
    .ext_wake1_in(wk1), .deep_sleep_state_in(slp), .power_mgmt_flag_in(src[0]),
    .rtc_alarm_flag_in(src[1] & ~alt[1]), .rtc_interval_flag_in(src[1] & alt[1]),
    .energy_irq_flag_in(src[2]), .watchdog_timeout_flag_in(src[3]), .temperature_event_in(tev),
    .serial_bus_event_in(sev), .timer_zero_overflow_in(src[6]), .timer_one_overflow_in(src[8]),
    .timer_two_overflow_in(src[11] & ~alt[11]), .timer_two_external_flag_in(src[11] & alt[11]),
    .uart_rx_flag_in(src[10] & ~alt[10]), .uart_tx_flag_in(src[10] & alt[10]),
    .second_uart_rx_flag_in(src[12] & ~alt[12]), .second_uart_tx_flag_in(src[12] & alt[12]),
    .instr_boundary_in(bnd), .return_from_interrupt_in(rfi), .irq_sfr_access_in(sfr),
    .vector_load_out(vl), .push_pc_out(push), .pop_pc_out(pop), .vector_addr_out(va),
    .flag_clear_out(fc), .ext_pin0_flag_out(x0), .ext_pin1_flag_out(x1), .in_service_out(is));

  core_model core (.clk_in(clk), .rst_b_in(rst_b), .slow_in(slow), .push_pc_in(push),
    .pop_pc_in(pop), .instr_boundary_out(bnd), .depth_out(depth));

  //////////////////////////////////////////////////////////////////////
  // drive just after the rising edge so no race with the design
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [15:0] vec(input int i);
    return 16'h0003 + {9'h000, SLOT[i], 3'h0};
  endfunction

  // only timers zero and one, and pins in edge mode, are cleared on entry
  function automatic logic [12:0] clr(input int i);
    logic [12:0] m;
    m = '0;
    if (i == 6 || i == 8 || (i == 5 && es0) || (i == 7 && es1)) m[i] = 1'b1;
    return m;
  endfunction

  // strict compare keeps the lowest index inside the best tier
  function automatic int win(input logic [12:0] q);
    int b;
    int bt;
    int t;
    b = -1;
    bt = -1;
    for (int i = 0; i < 13; i++) begin
      t = (i == 0) ? 2 : int'(hi[i]);
      if (q[i] && en[i] && t > bt) begin
        bt = t;
        b = i;
      end
    end
    return b;
  endfunction

  task automatic quiet(input int k);
    repeat (k) begin
      tick();
      chk("no_vector", 16'h0000, {15'h0000, vl});
    end
  endtask

  // bounded wait: a missing grant shows up as push low
  task automatic grant(input int i, input logic [2:0] e, input bit drop);
    n = 0;
    while (vl !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    chk("vector_addr", vec(i), va);
    chk("push", 16'h0001, {15'h0000, push});
    chk("flag_clear", {3'h0, clr(i)}, {3'h0, fc});
    chk("in_service", {13'h0000, e}, {13'h0000, is});
    if (drop) src[i] = 1'b0;
    quiet(4);
  endtask

  task automatic ret(input logic [2:0] e);
    chk("depth", 16'($countones(e)) + 16'h0001, {12'h000, depth});
    while (bnd !== 1'b1) tick();
    rfi = 1'b1;
    tick();
    rfi = 1'b0;
    chk("pop", 16'h0001, {15'h0000, pop});
    chk("in_service", {13'h0000, e}, {13'h0000, is});
    chk("no_vector", 16'h0000, {15'h0000, vl});
    quiet(1);
  endtask

  // sources settle with global enable low, so pin sync lag cannot reorder
  task automatic apply();
    src = p & ~13'h0210;
    tev = p[4];
    sev = p[9];
    tick();
    tev = 1'b0;
    sev = 1'b0;
    repeat (4) tick();
    ge = 1'b1;
  endtask

  task automatic drain();
    w = win(p);
    while (w >= 0) begin
      grant(w, (w == 0) ? 3'b100 : (hi[w] ? 3'b010 : 3'b001), 1'b1);
      p[w] = 1'b0;
      ret(3'b000);
      w = win(p);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    fail_count++;
    finish_test();
  end

  initial begin
    w = $urandom(32'h0108);
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk("reset_vector", 16'h0003, va);
    chk("reset_service", 16'h0000, {13'h0000, is});
    // every source at once, all priority bits low: poll order and full vector table
    en = '1;
    p = '1;
    apply();
    for (int k = 0; k < 13; k++) begin
      grant(k, (k == 0) ? 3'b100 : 3'b001, 1'b1);
      if (k == 0) chk("latency", 16'h0001, {15'h0000, n == LMIN});
      ret(3'b000);
    end
    quiet(12);
    // random mixes; disabled latched requests carry over
    p = '0;
    for (int it = 0; it < 24; it++) begin
      ge = 1'b0;
      slow = 1'($urandom);
      alt = 13'($urandom);
      hi = 13'($urandom);
      en = 13'($urandom);
      p = (p & 13'h0210) | 13'($urandom);
      p[$urandom % 13] = 1'b1;
      if (win(p) < 0) en = en | p;
      apply();
      drain();
      src = '0;
    end
    ge = 1'b0;
    en = '1;
    p = p & 13'h0210;
    apply();
    drain();
    // nesting: same tier waits, higher tier and power tier preempt
    slow = 1'b0;
    hi = 13'h0040;
    src[8] = 1'b1;
    grant(8, 3'b001, 1'b1);
    src[10] = 1'b1;
    quiet(8);
    src[6] = 1'b1;
    grant(6, 3'b011, 1'b1);
    src[0] = 1'b1;
    grant(0, 3'b111, 1'b1);
    ret(3'b011);
    ret(3'b001);
    ret(3'b000);
    grant(10, 3'b001, 1'b1);
    ret(3'b000);
    // gating: latched while globally or individually disabled
    ge = 1'b0;
    tev = 1'b1;
    tick();
    tev = 1'b0;
    quiet(8);
    en = '0;
    ge = 1'b1;
    quiet(8);
    en = 13'h0010;
    grant(4, 3'b001, 1'b1);
    ret(3'b000);
    // rtc request withdrawn by clearing its flag
    en = '1;
    ge = 1'b0;
    src[1] = 1'b1;
    tick();
    src[1] = 1'b0;
    ge = 1'b1;
    quiet(8);
    // pin 0 edge mode: cleared on entry, no re-entry while pin low
    es0 = 1'b1;
    src[5] = 1'b1;
    grant(5, 3'b001, 1'b0);
    chk("ext0_flag", 16'h0000, {15'h0000, x0});
    ret(3'b000);
    quiet(8);
    // leave edge mode only once the pin reads high, else level mode sees a stale low
    src[5] = 1'b0;
    repeat (4) tick();
    es0 = 1'b0;
    // pin 0 level mode: re-entered until the pin returns high
    src[5] = 1'b1;
    grant(5, 3'b001, 1'b0);
    ret(3'b000);
    grant(5, 3'b001, 1'b1);
    ret(3'b000);
    // pin 1 during deep sleep: flag frozen, wake leaves a request
    slp = 1'b1;
    src[7] = 1'b1;
    repeat (6) tick();
    chk("ext1_flag", 16'h0000, {15'h0000, x1});
    src[7] = 1'b0;
    repeat (4) tick();
    wk1 = 1'b1;
    tick();
    wk1 = 1'b0;
    slp = 1'b0;
    grant(7, 3'b001, 1'b1);
    ret(3'b000);
    // enable access: one more instruction must finish before vectoring
    sfr = 1'b1;
    src[8] = 1'b1;
    tick();
    sfr = 1'b0;
    chk("no_vector", 16'h0000, {15'h0000, vl});
    quiet(1);
    grant(8, 3'b001, 1'b1);
    ret(3'b000);
    finish_test();
  end
endmodule
